// ---- shared/ats_pkg.sv ----
// Constants, types and register map of the absolute time keeper.
// Assumes a single 10 MHz system clock and a plain register port.
package ats_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
	localparam int US_PER_SEC = 1_000_000;
	localparam int PPS_TOL_US = 100;
	localparam int NMEA_TIMEOUT_S = 2;
	localparam logic [31:0] VIRTUAL_START_S = 32'h0000_0000;
	// Firing geometry: times in nanoseconds, then channel and block counts
	localparam int LAST_BLOCK_NS = 5632;
	localparam int BLOCK_STEP_NS = 50000;
	localparam int CH_STEP_NS = 2888;
	localparam int CH_BASE_NS = 368;
	localparam int CH_PER_BANK = 16;
	localparam int CHANNELS = 32;
	localparam int BLOCKS_SINGLE = 8;
	localparam int BLOCKS_TRIPLE = 6;
	// Register map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_SECONDS = 4'h8;
	localparam logic [3:0] REG_MICROS = 4'hc;
	localparam int CTRL_SRC_BIT = 0;
	localparam int CTRL_SENT_BIT = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam int STAT_PPS_LSB = 0;
	localparam int STAT_NMEA_LSB = 2;
	localparam int STAT_PTP_LSB = 4;

	typedef enum logic {SRC_GNSS, SRC_PTP} ats_src_t;
	typedef enum logic {SENT_RMC, SENT_GGA} ats_sent_t;
	typedef enum logic [1:0] {LK_UNLOCKED, LK_LOCKED, LK_LOST} ats_lock_t;
	typedef enum logic [1:0] {PTP_FREE_RUN, PTP_TRACKING, PTP_LOCKED, PTP_FROZEN} ats_ptp_t;
	typedef enum logic [1:0] {RET_SINGLE, RET_DUAL, RET_TRIPLE} ats_ret_t;

	typedef struct packed {
		logic [31:0] seconds;
		logic [19:0] micros;
	} ats_time_t;

	typedef struct packed {
		ats_sent_t kind;
		logic [31:0] seconds;
	} ats_sentence_t;
endpackage

// ---- hw/ats_sync2.sv ----
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the inputs are quasi-static relative to sys_clk.
module ats_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	generate
		if (WIDTH < 1) begin : g_chk
			$error("ats_sync2: WIDTH must be at least 1");
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// ---- hw/ats_fire_calc.sv ----
// Firing time of one channel of one block, relative to packet time.
// Purely combinational; the caller registers the result.
module ats_fire_calc (
	input wire ats_pkg::ats_ret_t ret_mode,
	input wire logic [3:0] block,
	input wire logic [5:0] channel,
	output logic signed [31:0] offset_ns
);
	logic [3:0] steps;
	logic [3:0] back;

	// Channel index within its bank of sixteen, zero based
	function automatic logic [31:0] chan_offset(input logic [5:0] n);
		logic [5:0] idx;
		idx = (n > 6'(ats_pkg::CH_PER_BANK)) ? 6'(n - 6'(ats_pkg::CH_PER_BANK) - 6'd1)
			: 6'(n - 6'd1);
		return 32'(ats_pkg::CH_STEP_NS) * 32'(idx) + 32'(ats_pkg::CH_BASE_NS);
	endfunction

	always_comb begin
		back = 4'(ats_pkg::BLOCKS_SINGLE) - block;
		case (ret_mode)
			ats_pkg::RET_DUAL: steps = back >> 1;
			ats_pkg::RET_TRIPLE: steps = 4'((4'(ats_pkg::BLOCKS_TRIPLE) - block) / 4'd3);
			default: steps = back;
		endcase
		// Block start plus channel offset
		offset_ns = 32'(ats_pkg::LAST_BLOCK_NS) - 32'(ats_pkg::BLOCK_STEP_NS) * 32'(steps)
			+ chan_offset(channel);
	end
endmodule

// ---- hw/ats_top.sv ----
// Absolute time keeper: 1 Hz tick, second and microsecond counters,
// source lock tracking, packet timestamps and firing offsets.
// Assumes a sentence parser and a protocol engine on sys_clk; the
// pulse-per-second pin is asynchronous.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
module ats_top #(
	parameter int US_PER_SEC = ats_pkg::US_PER_SEC,
	parameter int PPS_TOL_US = ats_pkg::PPS_TOL_US,
	parameter int NMEA_TIMEOUT_S = ats_pkg::NMEA_TIMEOUT_S
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic pps_pin,
	input wire logic sentence_valid,
	input wire ats_pkg::ats_sentence_t sentence,
	input wire ats_pkg::ats_ptp_t ptp_state,
	input wire logic ptp_time_valid,
	input wire ats_pkg::ats_time_t ptp_time,
	input wire logic pkt_req,
	input wire logic fire_req,
	input wire logic [3:0] fire_block,
	input wire logic [5:0] fire_channel,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic tick_1hz,
	output logic gnss_packet,
	output ats_pkg::ats_time_t now,
	output ats_pkg::ats_time_t packet_absolute_time,
	output logic packet_valid,
	output ats_pkg::ats_time_t fire_base,
	output logic signed [31:0] fire_offset_ns,
	output logic fire_valid
);
	localparam int US_MAX = US_PER_SEC + PPS_TOL_US;
	localparam logic [3:0] CYC_LAST = 4'(ats_pkg::CYC_PER_US - 1);

	generate
		if (US_MAX >= (1 << 20) || US_PER_SEC < 2 || ats_pkg::CYC_PER_US > 16
			|| ats_pkg::CYC_PER_US < 1) begin : g_chk
			$error("ats_top: timing parameters out of range");
		end
	endgenerate

	logic [3:0] ctrl;
	ats_pkg::ats_src_t src_sel;
	ats_pkg::ats_sent_t sent_sel;
	ats_pkg::ats_ret_t ret_mode;
	logic pps_sync;
	logic pps_prev;
	logic pps_rise;
	ats_pkg::ats_lock_t pps_lock;
	ats_pkg::ats_lock_t nmea_lock;
	logic [3:0] cyc_cnt;
	logic us_strobe;
	logic [19:0] us_cnt;
	logic free_wrap;
	logic tick;
	logic [31:0] seconds;
	logic [31:0] sent_seconds;
	logic sent_fresh;
	logic [7:0] miss_cnt;
	logic ptp_sync;
	logic signed [31:0] calc_ns;

	assign src_sel = ats_pkg::ats_src_t'(ctrl[ats_pkg::CTRL_SRC_BIT]);
	assign sent_sel = ats_pkg::ats_sent_t'(ctrl[ats_pkg::CTRL_SENT_BIT]);
	assign ret_mode = ats_pkg::ats_ret_t'(ctrl[ats_pkg::CTRL_MODE_LSB +: 2]);

	ats_sync2 #(
		.WIDTH(1)
	) u_pps_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in(pps_pin),
		.sync_out(pps_sync)
	);

	ats_fire_calc u_fire_calc (
		.ret_mode(ret_mode),
		.block(fire_block),
		.channel(fire_channel),
		.offset_ns(calc_ns)
	);

	// Control register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= ats_pkg::CTRL_RESET;
		end else if (reg_wr && reg_addr == ats_pkg::REG_CTRL) begin
			ctrl <= reg_wdata[3:0];
		end
	end

	// Read port: data stands in the cycle after the strobe only
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_addr == ats_pkg::REG_CTRL) begin
			reg_rdata <= {28'h000_0000, ctrl};
		end else if (reg_addr == ats_pkg::REG_STATUS) begin
			reg_rdata <= {26'h000_0000, ptp_state, nmea_lock, pps_lock};
		end else if (reg_addr == ats_pkg::REG_SECONDS) begin
			reg_rdata <= seconds;
		end else if (reg_addr == ats_pkg::REG_MICROS) begin
			reg_rdata <= {12'h000, us_cnt};
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Pulse edge detect reads only the synchroniser's second flop
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pps_prev <= 1'b0;
		end else begin
			pps_prev <= pps_sync;
		end
	end
	assign pps_rise = pps_sync && !pps_prev && src_sel == ats_pkg::SRC_GNSS;

	// Microsecond prescaler
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cyc_cnt <= 4'h0;
		end else if (tick || cyc_cnt == CYC_LAST) begin
			cyc_cnt <= 4'h0;
		end else begin
			cyc_cnt <= cyc_cnt + 4'h1;
		end
	end
	assign us_strobe = cyc_cnt == CYC_LAST;

	// A locked pulse stretches the second by the tolerance before giving up
	assign free_wrap = us_strobe && (pps_lock == ats_pkg::LK_LOCKED
		? us_cnt == 20'(US_MAX - 1) : us_cnt == 20'(US_PER_SEC - 1));

	always_comb begin
		if (src_sel == ats_pkg::SRC_GNSS && pps_lock == ats_pkg::LK_LOCKED) begin
			tick = pps_rise || free_wrap;
		end else begin
			tick = free_wrap;
		end
	end

	// Pulse lock tracking
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pps_lock <= ats_pkg::LK_UNLOCKED;
		end else if (pps_rise) begin
			pps_lock <= ats_pkg::LK_LOCKED;
		end else if (pps_lock == ats_pkg::LK_LOCKED && free_wrap) begin
			pps_lock <= ats_pkg::LK_LOST;
		end
	end

	// Any pulse edge in satellite source mode while not locked realigns the tick too
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			us_cnt <= 20'h0_0000;
		end else if (src_sel == ats_pkg::SRC_PTP && ptp_sync && ptp_time_valid) begin
			us_cnt <= ptp_time.micros;
		end else if (tick || pps_rise) begin
			us_cnt <= 20'h0_0000;
		end else if (us_strobe) begin
			us_cnt <= us_cnt + 20'h0_0001;
		end
	end

	// Sentence capture; a new sentence in the tick cycle stays fresh
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sent_seconds <= ats_pkg::VIRTUAL_START_S;
			sent_fresh <= 1'b0;
		end else if (sentence_valid && sentence.kind == sent_sel) begin
			sent_seconds <= sentence.seconds;
			sent_fresh <= 1'b1;
		end else if (tick) begin
			sent_fresh <= 1'b0;
		end
	end

	// Sentence lock: lost after a run of ticks with no sentence
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			nmea_lock <= ats_pkg::LK_UNLOCKED;
			miss_cnt <= 8'h00;
		end else if (src_sel != ats_pkg::SRC_GNSS) begin
			miss_cnt <= 8'h00;
		end else if (sentence_valid && sentence.kind == sent_sel) begin
			nmea_lock <= ats_pkg::LK_LOCKED;
			miss_cnt <= 8'h00;
		end else if (tick && !sent_fresh && nmea_lock == ats_pkg::LK_LOCKED) begin
			if (miss_cnt == 8'(NMEA_TIMEOUT_S - 1)) begin
				nmea_lock <= ats_pkg::LK_LOST;
			end else begin
				miss_cnt <= miss_cnt + 8'h01;
			end
		end
	end

	assign ptp_sync = ptp_state == ats_pkg::PTP_TRACKING || ptp_state == ats_pkg::PTP_LOCKED;

	// Whole-second counter
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			seconds <= ats_pkg::VIRTUAL_START_S;
		end else if (src_sel == ats_pkg::SRC_PTP) begin
			if (ptp_sync && ptp_time_valid) begin
				seconds <= ptp_time.seconds;
			end else if (tick) begin
				seconds <= seconds + 32'h0000_0001;
			end
		end else if (tick) begin
			if (nmea_lock == ats_pkg::LK_LOCKED && sent_fresh) begin
				seconds <= sent_seconds + 32'h0000_0001;
			end else begin
				seconds <= seconds + 32'h0000_0001;
			end
		end
	end

	// Tick and satellite time packet strobes
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tick_1hz <= 1'b0;
			gnss_packet <= 1'b0;
		end else begin
			tick_1hz <= tick;
			gnss_packet <= tick && src_sel == ats_pkg::SRC_GNSS;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			now <= '0;
		end else begin
			now <= '{seconds: seconds, micros: us_cnt};
		end
	end

	// Packet timestamp: whole second plus microsecond part
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			packet_absolute_time <= '0;
			packet_valid <= 1'b0;
		end else begin
			packet_valid <= pkt_req;
			if (pkt_req) begin
				packet_absolute_time <= '{seconds: seconds, micros: us_cnt};
			end
		end
	end

	// Firing time of the requested block and channel
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fire_base <= '0;
			fire_offset_ns <= 32'sh0000_0000;
			fire_valid <= 1'b0;
		end else begin
			fire_valid <= fire_req;
			if (fire_req) begin
				fire_base <= packet_absolute_time;
				fire_offset_ns <= calc_ns;
			end
		end
	end
endmodule

// ---- verif/ats_chk.sv ----
// Port-level checker of the absolute time keeper.
// Assumes one clock domain; bound to every ats_top.
module ats_chk #(
	parameter int US_PER_SEC = 100,
	parameter int PPS_TOL_US = 5
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic pps_pin,
	input wire logic pkt_req,
	input wire logic fire_req,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire ats_pkg::ats_ptp_t ptp_state,
	input wire logic ptp_time_valid,
	input wire logic tick_1hz,
	input wire logic gnss_packet,
	input wire ats_pkg::ats_time_t now,
	input wire ats_pkg::ats_time_t packet_absolute_time,
	input wire logic packet_valid,
	input wire ats_pkg::ats_time_t fire_base,
	input wire logic fire_valid
);
	localparam int LOCK_WIN = US_PER_SEC * ats_pkg::CYC_PER_US;
	logic src_ptp;
	logic src_d;
	logic pps_q;
	int gap;
	int since_rise;
	// Cycles since the previous pulse edge; a pulse this close keeps the lock
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pps_q <= 1'b0;
			since_rise <= LOCK_WIN;
		end else begin
			pps_q <= pps_pin;
			if (pps_pin && !pps_q)
				since_rise <= 0;
			else if (since_rise < LOCK_WIN)
				since_rise <= since_rise + 1;
		end
	end
	// Source bit is shadowed here; the delayed copy masks the switch-over cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			src_ptp <= 1'b0;
			src_d <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == ats_pkg::REG_CTRL)
				src_ptp <= reg_wdata[ats_pkg::CTRL_SRC_BIT];
			src_d <= src_ptp;
		end
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			gap <= 0;
		else if (tick_1hz || ptp_time_valid || (pps_pin && !pps_q))
			gap <= 0;
		else
			gap <= gap + 1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_gnss_on_tick: assert property (tick_1hz && !src_ptp && !src_d |-> gnss_packet)
		else $error("time packet missing at tick");
	a_pkt_with_tick: assert property (gnss_packet |-> tick_1hz)
		else $error("time packet without tick");
	a_ptp_silent: assert property (src_ptp && src_d |-> !gnss_packet)
		else $error("time packet in protocol mode");
	a_us_clear: assert property (tick_1hz && !src_ptp |=> now.micros == 20'h0_0000)
		else $error("microseconds not cleared at tick");
	a_tick_gap: assert property (gap <= (US_PER_SEC + PPS_TOL_US) * 10 + 20)
		else $error("tick interval too long");
	a_pps_align: assert property ($rose(pps_pin) && !src_ptp && !src_d && since_rise < LOCK_WIN
		|-> ##[2:4] tick_1hz)
		else $error("tick not aligned to pulse");
	a_pkt_valid: assert property (pkt_req |=> packet_valid)
		else $error("packet time not flagged");
	a_fire_base: assert property (fire_req |=> fire_valid && fire_base == $past(packet_absolute_time))
		else $error("fire base not packet time");
	a_stat_ptp: assert property (reg_rd && reg_addr == ats_pkg::REG_STATUS |=> reg_rdata[5:4] == $past(ptp_state))
		else $error("protocol state misreported");
endmodule
bind ats_top ats_chk #(.US_PER_SEC(US_PER_SEC), .PPS_TOL_US(PPS_TOL_US)) u_chk (
	.sys_clk(sys_clk), .nrst(nrst), .pps_pin(pps_pin), .pkt_req(pkt_req),
	.fire_req(fire_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ptp_state(ptp_state),
	.ptp_time_valid(ptp_time_valid), .tick_1hz(tick_1hz), .gnss_packet(gnss_packet),
	.now(now), .packet_absolute_time(packet_absolute_time), .packet_valid(packet_valid),
	.fire_base(fire_base), .fire_valid(fire_valid));

// ---- verif/ats_rx_model.sv ----
// Satellite receiver model: pulse per second and time sentences.
// Assumes sys_clk timing; pulse period is a parameter in cycles.
module ats_rx_model #(
	parameter int PER = 700
) (
	input wire logic sys_clk,
	input wire logic pps_on,
	input wire logic nmea_on,
	input wire ats_pkg::ats_sent_t kind,
	input wire logic [31:0] secs,
	output logic pps_pin,
	output logic sentence_valid,
	output ats_pkg::ats_sentence_t sentence
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial begin
		pps_pin = 1'b0;
		sentence_valid = 1'b0;
		sentence = '0;
	end
	always @(posedge sys_clk) begin
		cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
		pps_pin <= pps_on && cnt < 10;
		sentence_valid <= nmea_on && cnt == 50;
		// Outside the valid cycle the data toggles so stale values never match
		if (nmea_on && cnt == 50)
			sentence <= {kind, secs};
		else
			sentence <= ~sentence;
	end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench of the absolute time keeper.
// Assumes shortened second of 100 us; receiver model on the pulse inputs.
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: got %0h exp %0h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TPC = 100 * ats_pkg::CYC_PER_US;
	logic sys_clk = 0, nrst = 0, pps_on = 0, nmea_on = 0, pps_pin, sentence_valid;
	logic ptp_time_valid = 0, pkt_req = 0, fire_req = 0, reg_wr = 0, reg_rd = 0;
	logic tick_1hz, gnss_packet, packet_valid, fire_valid, gp;
	logic [3:0] fire_block = 0, reg_addr = 0;
	logic [5:0] fire_channel = 0;
	logic [31:0] secs = 0, rd_d, reg_wdata = 0, reg_rdata;
	logic signed [31:0] fire_offset_ns;
	ats_pkg::ats_sent_t kind = ats_pkg::SENT_RMC;
	ats_pkg::ats_sentence_t sentence;
	ats_pkg::ats_ptp_t ptp_state = ats_pkg::PTP_FREE_RUN;
	ats_pkg::ats_time_t ptp_time = '0, now, pat, fire_base;
	int n_mismatch = 0, tests_run = 0, cyc = 0, gap, m, b, n;
	ats_top #(.US_PER_SEC(100), .PPS_TOL_US(5), .NMEA_TIMEOUT_S(2)) u_dut (
		.sys_clk(sys_clk), .nrst(nrst), .pps_pin(pps_pin), .sentence_valid(sentence_valid),
		.sentence(sentence), .ptp_state(ptp_state), .ptp_time_valid(ptp_time_valid),
		.ptp_time(ptp_time), .pkt_req(pkt_req), .fire_req(fire_req), .fire_block(fire_block),
		.fire_channel(fire_channel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_1hz(tick_1hz),
		.gnss_packet(gnss_packet), .now(now), .packet_absolute_time(pat),
		.packet_valid(packet_valid), .fire_base(fire_base), .fire_offset_ns(fire_offset_ns),
		.fire_valid(fire_valid));
	ats_rx_model #(.PER(700)) u_rx (.sys_clk(sys_clk), .pps_on(pps_on), .nmea_on(nmea_on),
		.kind(kind), .secs(secs), .pps_pin(pps_pin), .sentence_valid(sentence_valid),
		.sentence(sentence));
	initial forever #50 sys_clk = ~sys_clk;
	function automatic int exp_off(int m, int b, int n);
		int k = (m == 0) ? 8 - b : (m == 1) ? (8 - b) / 2 : (6 - b) / 3;
		return 5632 - 50000 * k + 2888 * ((n - 1) % 16) + 368;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge sys_clk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge sys_clk);
		reg_rd <= 0;
		#1 rd_d = reg_rdata;
	endtask
	// Bounded wait; gap ends up as the cycle count since the previous tick
	task automatic wait_tick;
		// Starts at one: the trailing cycle below belongs to the next interval
		gap = 1;
		do begin
			@(posedge sys_clk);
			#1 gap++;
		end while (tick_1hz !== 1'b1 && gap < 3 * TPC);
		`CHK(tick_1hz, 1'b1)
		gp = gnss_packet;
		// The time copy on now lags the tick by one cycle
		@(posedge sys_clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(83407));
		repeat (16) @(posedge sys_clk);
		nrst <= 1;
		rd(ats_pkg::REG_CTRL);
		`CHK(rd_d, 32'h0000_0000)
		rd(ats_pkg::REG_STATUS);
		`CHK(rd_d, 32'h0000_0000)
		rd(4'h2);
		`CHK(rd_d, 32'h0000_0000)
		$display("test reset done");
		wait_tick();
		`CHK(now.seconds, 32'h0000_0001)
		`CHK(gp, 1'b1)
		wait_tick();
		`CHK(gap, TPC)
		`CHK(now.seconds, 32'h0000_0002)
		// Stamp taken two microseconds into the second, so both parts count
		repeat (25) @(posedge sys_clk);
		@(posedge sys_clk);
		pkt_req <= 1;
		@(posedge sys_clk);
		pkt_req <= 0;
		#1 `CHK(pat.seconds, 32'h0000_0002)
		`CHK(pat.micros, 20'h0_0002)
		`CHK(packet_valid, 1'b1)
		$display("test free run done");
		for (int i = 0; i < 24; i++) begin
			m = i % 3;
			b = (i < 3) ? 8 - 2 * m : 1 + $urandom % ((m == 2) ? 6 : 8);
			n = (i < 3) ? 1 + 15 * i : 1 + $urandom % 32;
			wr(ats_pkg::REG_CTRL, 32'(m) << ats_pkg::CTRL_MODE_LSB);
			@(posedge sys_clk);
			fire_block <= 4'(b);
			fire_channel <= 6'(n);
			fire_req <= 1;
			@(posedge sys_clk);
			fire_req <= 0;
			#1 `CHK(fire_offset_ns, 32'(exp_off(m, b, n)))
			`CHK(fire_valid, 1'b1)
			`CHK(fire_base, {32'h0000_0002, 20'h0_0002})
		end
		wr(ats_pkg::REG_CTRL, 32'h0000_0000);
		$display("test firing done");
		secs <= $urandom & 32'h0fff_ffff;
		nmea_on <= 1;
		wait_tick();
		wait_tick();
		`CHK(now.seconds, secs + 1)
		rd(ats_pkg::REG_STATUS);
		`CHK(rd_d[3:2], ats_pkg::LK_LOCKED)
		kind = ats_pkg::SENT_GGA;
		repeat (3) wait_tick();
		`CHK(now.seconds, secs + 4)
		rd(ats_pkg::REG_STATUS);
		`CHK(rd_d[3:2], ats_pkg::LK_LOST)
		nmea_on = 0;
		$display("test sentences done");
		pps_on = 1;
		repeat (3) wait_tick();
		`CHK(gap, 700)
		rd(ats_pkg::REG_STATUS);
		`CHK(rd_d[1:0], ats_pkg::LK_LOCKED)
		pps_on = 0;
		repeat (2) wait_tick();
		rd(ats_pkg::REG_STATUS);
		`CHK(rd_d[1:0], ats_pkg::LK_LOST)
		$display("test pulse done");
		wr(ats_pkg::REG_CTRL, 32'h0000_0001);
		for (int s = 0; s < 4; s++) begin
			ptp_state <= ats_pkg::ats_ptp_t'(s);
			rd(ats_pkg::REG_STATUS);
			`CHK(rd_d[5:4], 2'(s))
		end
		@(posedge sys_clk);
		ptp_state <= ats_pkg::PTP_TRACKING;
		ptp_time <= {$urandom & 32'h0fff_ffff, 20'($urandom % 50)};
		ptp_time_valid <= 1;
		@(posedge sys_clk);
		ptp_time_valid <= 0;
		repeat (2) @(posedge sys_clk);
		#1 `CHK(now.seconds, ptp_time.seconds)
		ptp_state <= ats_pkg::PTP_FROZEN;
		wait_tick();
		`CHK(now.seconds, ptp_time.seconds + 1)
		`CHK(gp, 1'b0)
		$display("test protocol done");
		wrap_up();
	end
endmodule
